// File: hw/bim_io_matrix.sv
`timescale 1ns/100ps
`include "bim_consts.svh"
module bim_io_matrix #(
   parameter int N_DI     = `BIM_N_DI,
   parameter int N_DO     = `BIM_N_DO,
   parameter int N_LED    = `BIM_N_LED,
   parameter int N_LI     = `BIM_N_LI,
   parameter int N_LO     = `BIM_N_LO,
   parameter int N_NET    = `BIM_N_NET,
   parameter int N_STG    = 32,
   parameter int N_PSW    = `BIM_N_PSW,
   parameter int TICK_CYC = `BIM_TICK_CYC,
   parameter int DET_MS   = `BIM_DET_MS,
   parameter int OUT_MS   = `BIM_OUT_OP_MS,
   parameter int N_SRC    = N_DI + N_LO + N_STG
) (
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   full_reset,
   input  wire logic                   soft_reset,
   input  wire logic [N_DI-1:0]        di_pin,
   input  wire logic [N_DI-1:0]        di_nc,
   input  wire logic [N_DI*21-1:0]     di_act_ms,
   input  wire logic [N_DI*21-1:0]     di_rel_ms,
   input  wire logic [N_DI-1:0]        di_ev_mask,
   output logic [N_DI-1:0]             di_state,
   output logic [N_DI-1:0]             di_event,
   input  wire logic [N_DO-1:0]        do_nc,
   output logic [N_DO-1:0]             do_contact,
   input  wire logic [N_LED-1:0]       led_yellow_set,
   output logic [N_LED-1:0]            led_on,
   output logic [N_LED-1:0]            led_yellow,
   input  wire logic [N_STG-1:0]       stage_status,
   input  wire logic [N_DO*N_SRC-1:0]  do_route,
   input  wire logic [N_DO*N_SRC-1:0]  do_latch,
   input  wire logic [N_LED*N_SRC-1:0] led_route,
   input  wire logic [N_LED*N_SRC-1:0] led_latch,
   input  wire logic                   latch_clear,
   input  wire logic                   back_key,
   input  wire logic                   mimic_shown,
   input  wire logic                   li_wr,
   input  wire logic                   li_wr_super,
   input  wire logic [4:0]             li_idx,
   input  wire logic                   li_val,
   input  wire logic [N_LI-1:0]        li_pulse_mode,
   output logic [N_LI-1:0]             li_state,
   input  wire logic [N_LO-1:0]        lo_gate,
   input  wire logic [N_LO-1:0]        lo_connected,
   input  wire logic [2*N_LI-1:0]      li_ev_mask,
   input  wire logic [2*N_LO-1:0]      lo_ev_mask,
   output logic [2*N_LI-1:0]           li_event,
   output logic [2*N_LO-1:0]           lo_event,
   output logic [N_LO-1:0]             lo_state,
   input  wire logic [N_NET-1:0]       net_bit,
   input  wire logic [N_NET-1:0]       net_msg_ok,
   output logic [N_NET-1:0]            net_state,
   output logic [N_NET-1:0]            net_quality,
   input  wire logic                   psw_op,
   input  wire logic [2:0]             psw_idx,
   input  wire bim_pkg::bim_level_t    psw_user_lvl,
   input  wire logic [N_PSW*2-1:0]     psw_need_lvl,
   output logic [N_PSW-1:0]            psw_state,
   output logic                        psw_refused
);
   import bim_pkg::*;
   localparam int OUT_CYC = OUT_MS * TICK_CYC;

   ////////////////////////////////////////////////////////////////////////
   // millisecond tick shared by the input delay counters
   logic [31:0] tick_cnt_q;
   logic        tick_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == 32'(TICK_CYC - 1)) begin
         tick_cnt_q <= 32'h0000_0000;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         tick_q     <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // digital inputs: sync, polarity, filter plus user delay
   logic [N_DI-1:0] di_s1_q, di_s2_q, di_q, di_ev_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         di_s1_q <= '0;
         di_s2_q <= '0;
      end else begin
         di_s1_q <= di_pin;
         di_s2_q <= di_s1_q;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < N_DI; gi++) begin : g_di
         logic [21:0] cnt_q;
         logic        raw;
         logic [21:0] lim;
         assign raw = di_s2_q[gi] ^ di_nc[gi];
         // fixed filter is added so even zero delay meets the 5 ms floor
         assign lim = raw ? 22'(di_act_ms[gi*21 +: 21]) + 22'(DET_MS)
                          : 22'(di_rel_ms[gi*21 +: 21]) + 22'(DET_MS);
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cnt_q       <= '0;
               di_q[gi]    <= 1'b0;
               di_ev_q[gi] <= 1'b0;
            end else begin
               di_ev_q[gi] <= 1'b0;
               if (raw == di_q[gi]) begin
                  cnt_q <= '0;
               end else if (tick_q) begin
                  if (cnt_q + 22'd1 >= lim) begin
                     cnt_q       <= '0;
                     di_q[gi]    <= raw;
                     di_ev_q[gi] <= di_ev_mask[gi];
                  end else begin
                     cnt_q <= cnt_q + 22'd1;
                  end
               end
            end
         end
      end
   endgenerate
   assign di_state = di_q;
   assign di_event = di_ev_q;

   ////////////////////////////////////////////////////////////////////////
   // logical inputs and panel switches
   logic [N_LI-1:0] li_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         li_q <= '0;
      end else begin
         li_q <= li_q & ~li_pulse_mode;
         if (li_wr || li_wr_super) begin
            li_q[li_idx] <= li_pulse_mode[li_idx] | li_val;
         end
      end
   end
   assign li_state = li_q;
   sequence s_pulse_wr;
      (li_wr || li_wr_super) && li_pulse_mode[li_idx];
   endsequence
   sequence s_no_wr;
      !(li_wr || li_wr_super);
   endsequence
   sequence s_pulse_seen;
      (li_q & li_pulse_mode) != '0;
   endsequence
   sequence s_pulse_gone;
      (li_q & li_pulse_mode) == '0;
   endsequence
   AST_PULSE_WR: assert property (@(posedge clk) disable iff (rst)
      s_pulse_wr ##1 s_no_wr |-> s_pulse_seen ##1 s_pulse_gone)
      else $error("pulse input missed");
   AST_HOLD_WR: assert property (@(posedge clk) disable iff (rst)
      (li_wr || li_wr_super) && !li_pulse_mode[li_idx]
      |=> li_q[$past(li_idx)] == $past(li_val))
      else $error("hold input not written");

   logic [N_PSW-1:0] psw_q;
   logic             psw_ref_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         psw_q     <= '0;
         psw_ref_q <= 1'b0;
      end else begin
         psw_ref_q <= 1'b0;
         if (psw_op) begin
            if (psw_user_lvl < bim_level_t'(psw_need_lvl[psw_idx*2 +: 2]))
               psw_ref_q <= 1'b1;
            else
               psw_q[psw_idx] <= ~psw_q[psw_idx];
         end
      end
   end
   assign psw_state   = psw_q;
   assign psw_refused = psw_ref_q;

   ////////////////////////////////////////////////////////////////////////
   // logical outputs, events, network bits
   logic [N_LO-1:0]    lo_q;
   logic [N_LI-1:0]    li_prev_q;
   logic [2*N_LI-1:0]  li_ev_q;
   logic [2*N_LO-1:0]  lo_ev_q;
   logic [N_NET-1:0]   net_q, netq_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lo_q      <= '0;
         li_prev_q <= '0;
         li_ev_q   <= '0;
         lo_ev_q   <= '0;
      end else begin
         // a gate with no output attached stays silent
         lo_q      <= lo_gate & lo_connected;
         li_prev_q <= li_q;
         li_ev_q   <= {li_prev_q & ~li_q, li_q & ~li_prev_q}
                      & li_ev_mask;
         lo_ev_q   <= {lo_q & ~(lo_gate & lo_connected),
                       ~lo_q & lo_gate & lo_connected}
                      & lo_ev_mask;
      end
   end
   assign lo_state = lo_q;
   assign li_event = li_ev_q;
   assign lo_event = lo_ev_q;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         net_q  <= '0;
         netq_q <= {N_NET{1'b1}};
      end else begin
         net_q  <= net_bit;
         netq_q <= ~net_msg_ok;
      end
   end
   assign net_state   = net_q;
   assign net_quality = netq_q;

   ////////////////////////////////////////////////////////////////////////
   // routing matrix with latches
   logic [N_SRC-1:0] src;
   logic             clr_all;
   assign src     = {stage_status, lo_q, di_q};
   assign clr_all = latch_clear | (back_key & mimic_shown);

   logic [N_DO-1:0]  do_lat_q, do_drv;
   logic [N_LED-1:0] led_lat_q, led_q;
   logic [N_LED-1:0] led_set;
   generate
      for (gi = 0; gi < N_DO; gi++) begin : g_do
         logic [N_SRC-1:0] r, l;
         assign r = do_route[gi*N_SRC +: N_SRC];
         assign l = do_latch[gi*N_SRC +: N_SRC];
         always_ff @(posedge clk or posedge rst) begin
            if (rst)
               do_lat_q[gi] <= 1'b0;
            else if (|(src & r & l))
               do_lat_q[gi] <= 1'b1;
            else if (clr_all)
               do_lat_q[gi] <= 1'b0;
         end
         assign do_drv[gi] = |(src & r & ~l) | do_lat_q[gi];
      end
      for (gi = 0; gi < N_LED; gi++) begin : g_led
         logic [N_SRC-1:0] r, l;
         assign r = led_route[gi*N_SRC +: N_SRC];
         assign l = led_latch[gi*N_SRC +: N_SRC];
         assign led_set[gi] = |(src & r & l);
         AST_LED_DROP: assert property (
            @(posedge clk) disable iff (rst)
            !(|(src & r)) && !led_lat_q[gi] |=> !led_q[gi])
            else $error("led held without source");
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               led_lat_q[gi] <= 1'b0;
               led_q[gi]     <= 1'b0;
            end else begin
               if (|(src & r & l))
                  led_lat_q[gi] <= 1'b1;
               else if (clr_all)
                  led_lat_q[gi] <= 1'b0;
               led_q[gi] <= |(src & r & ~l) | led_lat_q[gi];
            end
         end
      end
   endgenerate
   assign led_on = led_q;

   logic [N_LED-1:0] led_col_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         led_col_q <= '0;
      else
         led_col_q <= led_yellow_set;
   end
   assign led_yellow = led_col_q;

   ////////////////////////////////////////////////////////////////////////
   // output contacts: operate delay then polarity
   logic [31:0]     op_cnt_q;
   logic [N_DO-1:0] pend_q, cont_q, nc_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_cnt_q <= 32'h0000_0000;
         pend_q   <= '0;
      end else if (do_drv != pend_q || full_reset) begin
         op_cnt_q <= 32'h0000_0000;
         pend_q   <= do_drv;
      end else if (op_cnt_q != 32'(OUT_CYC)) begin
         op_cnt_q <= op_cnt_q + 32'h0000_0001;
      end
   end
   // soft_reset does not touch nc_q or cont_q, so NC holds
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nc_q   <= '0;
         cont_q <= '0;
      end else if (full_reset) begin
         nc_q   <= '0;
         cont_q <= '0;
      end else begin
         nc_q <= do_nc;
         if (op_cnt_q == 32'(OUT_CYC - 1))
            cont_q <= pend_q ^ do_nc;
         else
            // only a moved polarity acts now, others keep their delay
            cont_q <= cont_q ^ ((cont_q ^ pend_q ^ do_nc) & (nc_q ^ do_nc));
      end
   end
   assign do_contact = cont_q;
   AST_OP_DELAY: assert property (@(posedge clk) disable iff (rst)
      $changed(cont_q) && !$past(full_reset) && $past(nc_q) == $past(do_nc)
      |-> $past(op_cnt_q) == 32'(OUT_CYC - 1))
      else $error("contact moved early");
   AST_SOFT_KEEP: assert property (@(posedge clk) disable iff (rst)
      soft_reset && !full_reset && nc_q == do_nc
      && op_cnt_q != 32'(OUT_CYC - 1) |=> $stable(cont_q))
      else $error("soft reset moved contact");

   ////////////////////////////////////////////////////////////////////////
   AST_PULSE_CLR: assert property (@(posedge clk) disable iff (rst)
      (li_q & li_pulse_mode) != '0 && !(li_wr || li_wr_super)
      |=> (li_q & $past(li_q) & $past(li_pulse_mode)) == '0)
      else $error("pulse input stuck");
   AST_BACK_CLR: assert property (@(posedge clk) disable iff (rst)
      back_key && mimic_shown && led_set == '0 |=> led_lat_q == '0)
      else $error("back key left latch");
   AST_FULL_NO: assert property (@(posedge clk) disable iff (rst)
      full_reset |=> cont_q == '0 && nc_q == '0)
      else $error("full reset kept contact");
   AST_QUAL: assert property (@(posedge clk) disable iff (rst)
      1'b1 |=> net_quality == ~$past(net_msg_ok))
      else $error("quality inverted wrongly");
   AST_GATE_SILENT: assert property (@(posedge clk) disable iff (rst)
      !lo_connected[0] |=> !lo_q[0])
      else $error("gate event");
   AST_REFUSE: assert property (@(posedge clk) disable iff (rst)
      psw_op && psw_user_lvl < bim_level_t'(psw_need_lvl[psw_idx*2 +: 2])
      |=> psw_refused && $stable(psw_q))
      else $error("switch not refused");
   AST_NOMASK: assert property (@(posedge clk) disable iff (rst)
      !$past(di_ev_mask[0]) |-> !di_ev_q[0])
      else $error("unmasked event");
   AST_DI_HOLD: assert property (@(posedge clk) disable iff (rst)
      $changed(di_q[0]) |-> $past(tick_q))
      else $error("input off tick");
endmodule

// File: hw/bim_consts.svh
`ifndef BIM_CONSTS_SVH
`define BIM_CONSTS_SVH
`define BIM_CLK_HZ        50000000
`define BIM_TICK_US       1000
`define BIM_TICK_CYC      ((`BIM_CLK_HZ / 1000000) * `BIM_TICK_US)
`define BIM_DLY_MAX_MS    1800000
`define BIM_DET_MS        5
`define BIM_OUT_OP_MS     5
`define BIM_N_DI          8
`define BIM_N_DO          8
`define BIM_N_LED         16
`define BIM_N_LI          32
`define BIM_N_LO          32
`define BIM_N_NET         64
`define BIM_N_PSW         8
`define BIM_N_SRC         (`BIM_N_DI + `BIM_N_LO + 32)
`endif

// File: hw/bim_pkg.sv
package bim_pkg;
   typedef enum logic [1:0] {
      BIM_LVL_USER,
      BIM_LVL_OPER,
      BIM_LVL_CONF,
      BIM_LVL_SUPER
   } bim_level_t;
   typedef enum logic {
      BIM_LED_GREEN,
      BIM_LED_YELLOW
   } bim_led_color_t;
endpackage

// File: sim/bim_field_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
// field side: wired contacts feeding the inputs, relay coils read back
module bim_field_model (
   input  wire logic [7:0] closed,
   input  wire logic       clk,
   input  wire logic [7:0] do_contact,
   output logic [7:0]      di_pin,
   output logic [7:0]      relay_closed
);
   // contacts move on the falling edge, away from the sampling edge
   always @(negedge clk) begin
      di_pin       <= closed;
      relay_closed <= do_contact;
   end
endmodule

// File: sim/bim_io_matrix_tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
   mismatches++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module bim_io_matrix_tb_top;
   import bim_pkg::*;
   logic clk, rst, full_reset, soft_reset, latch_clear, back_key, mimic_shown;
   logic li_wr, li_wr_super, li_val, psw_op, psw_refused, ref_seen;
   logic [7:0]    di_pin, di_nc, di_ev_mask, di_state, di_event, ev_di;
   logic [7:0]    do_nc, do_contact, closed, relay_closed, psw_state;
   logic [167:0]  di_act_ms, di_rel_ms;
   logic [15:0]   led_yellow_set, led_on, led_yellow, psw_need_lvl;
   logic [31:0]   stage_status, li_pulse_mode, li_state, lo_gate, lf, li_exp;
   logic [31:0]   lo_connected, lo_state;
   logic [575:0]  do_route, do_latch;
   logic [1151:0] led_route, led_latch;
   logic [4:0]    li_idx;
   logic [2:0]    psw_idx;
   logic [63:0]   li_ev_mask, lo_ev_mask, li_event, lo_event, ev_li, ev_lo;
   logic [63:0]   net_bit, net_msg_ok, net_state, net_quality;
   bim_level_t    psw_user_lvl;
   int            mismatches, n_checks, cyc, i;
   ////////////////////////////////////////////////////////////////////////
   // short tick keeps millisecond counts to a few cycles each
   bim_io_matrix #(.TICK_CYC(4)) u_bim_io_matrix (
      .clk, .rst, .full_reset, .soft_reset, .di_pin, .di_nc, .di_act_ms,
      .di_rel_ms, .di_ev_mask, .di_state, .di_event, .do_nc, .do_contact,
      .led_yellow_set, .led_on, .led_yellow, .stage_status, .do_route,
      .do_latch, .led_route, .led_latch, .latch_clear, .back_key,
      .mimic_shown, .li_wr, .li_wr_super, .li_idx, .li_val, .li_pulse_mode,
      .li_state, .lo_gate, .lo_connected, .li_ev_mask, .lo_ev_mask,
      .li_event, .lo_event, .lo_state, .net_bit, .net_msg_ok, .net_state,
      .net_quality, .psw_op, .psw_idx, .psw_user_lvl, .psw_need_lvl,
      .psw_state, .psw_refused
   );
   bim_field_model u_bim_field_model (
      .closed, .clk, .do_contact, .di_pin, .relay_closed
   );
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task nc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task li_write(input logic [4:0] idx, input logic v, input logic sup);
      li_idx      = idx;
      li_val      = v;
      li_wr       = !sup;
      li_wr_super = sup;
      nc(1);
      li_wr       = 1'b0;
      li_wr_super = 1'b0;
   endtask
   task psw_try(input bim_level_t lvl);
      psw_user_lvl = lvl;
      psw_op       = 1'b1;
      nc(1);
      psw_op       = 1'b0;
      nc(1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial clk = 1'b0;
   always #10 clk = ~clk;
   // pulses are one cycle wide, so keep a sticky copy for later checks
   always @(posedge clk) begin
      cyc++;
      ev_di    <= ev_di | di_event;
      ev_li    <= ev_li | li_event;
      ev_lo    <= ev_lo | lo_event;
      ref_seen <= ref_seen | psw_refused;
      if (cyc == 5000) begin
         mismatches++;
         end_of_test();
      end
   end
   initial begin
      {rst, full_reset, soft_reset, latch_clear, back_key, mimic_shown} = 0;
      {li_wr, li_wr_super, li_val, psw_op, ref_seen} = 0;
      {ev_di, ev_li, ev_lo, closed, do_nc, stage_status, lo_gate} = 0;
      {lo_connected, li_idx, net_bit, net_msg_ok, di_rel_ms} = 0;
      {do_route, do_latch, led_route, led_latch, li_exp} = 0;
      for (i = 0; i < 8; i++)
         di_act_ms[i*21+:21] = 21'd3;
      di_nc          = 8'h02;
      di_ev_mask     = 8'h01;
      led_yellow_set = 16'h0002;
      do_route[40]   = 1'b1;
      led_route[40]  = 1'b1;
      led_latch[40]  = 1'b1;
      led_route[112] = 1'b1;
      li_pulse_mode  = 32'h0000_0020;
      li_ev_mask     = 64'h0000_0000_0000_0008;
      lo_ev_mask     = '1;
      psw_idx        = 3'd2;
      psw_user_lvl   = BIM_LVL_USER;
      psw_need_lvl   = 16'h0020;
      lf             = 32'h0000_6fbb;
      rst            = 1'b1;
      nc(20);
      `CHK("net_quality", {64{1'b1}}, net_quality)
      rst = 1'b0;
      nc(60);
      `CHK("di_state", 8'h02, di_state)
      closed = 8'h01;
      nc(20);
      `CHK("di_state", 8'h02, di_state)
      nc(25);
      `CHK("di_state", 8'h03, di_state)
      `CHK("di_event", 2'b01, ev_di[1:0])
      stage_status = 32'h0000_0001;
      nc(3);
      `CHK("led_on", 2'b11, led_on[1:0])
      `CHK("led_yellow", 16'h0002, led_yellow)
      `CHK("do_contact", 1'b0, do_contact[0])
      nc(25);
      `CHK("do_contact", 1'b1, do_contact[0])
      `CHK("relay_closed", 1'b1, relay_closed[0])
      stage_status = 32'h0000_0000;
      nc(2);
      `CHK("led_on", 2'b01, led_on[1:0])
      back_key = 1'b1;
      nc(1);
      back_key = 1'b0;
      nc(2);
      `CHK("led_on", 2'b01, led_on[1:0])
      mimic_shown = 1'b1;
      back_key    = 1'b1;
      nc(1);
      back_key = 1'b0;
      nc(2);
      `CHK("led_on", 2'b00, led_on[1:0])
      mimic_shown  = 1'b0;
      stage_status = 32'h0000_0001;
      nc(3);
      stage_status = 32'h0000_0000;
      latch_clear  = 1'b1;
      nc(1);
      latch_clear = 1'b0;
      nc(2);
      `CHK("led_on", 2'b00, led_on[1:0])
      do_nc = 8'h02;
      nc(2);
      `CHK("do_contact", 1'b1, do_contact[1])
      soft_reset = 1'b1;
      nc(2);
      soft_reset = 1'b0;
      nc(1);
      `CHK("do_contact", 1'b1, do_contact[1])
      full_reset = 1'b1;
      nc(2);
      `CHK("do_contact", 1'b0, do_contact[1])
      full_reset = 1'b0;
      do_nc      = 8'h00;
      li_write(5'd3, 1'b1, 1'b0);
      nc(3);
      `CHK("li_state", 1'b1, li_state[3])
      li_write(5'd3, 1'b0, 1'b1);
      `CHK("li_state", 1'b0, li_state[3])
      nc(1);
      `CHK("li_event", 64'h0000_0000_0000_0008, ev_li)
      li_write(5'd5, 1'b0, 1'b0);
      `CHK("li_pulse", 1'b1, li_state[5])
      nc(1);
      `CHK("li_pulse", 1'b0, li_state[5])
      lo_gate = 32'h0000_0001;
      nc(4);
      `CHK("lo_event", 64'h0, ev_lo)
      lo_connected = 32'h0000_0001;
      nc(3);
      `CHK("lo_state", 1'b1, lo_state[0])
      `CHK("lo_event", 1'b1, ev_lo[0])
      psw_try(BIM_LVL_OPER);
      `CHK("psw_state", 8'h00, psw_state)
      `CHK("psw_refused", 1'b1, ref_seen)
      psw_try(BIM_LVL_SUPER);
      `CHK("psw_state", 8'h04, psw_state)
      for (i = 0; i < 20; i++) begin
         net_bit[31:0]  = lf;
         lf             = lfsr_next(lf);
         net_bit[63:32] = lf;
         lf             = lfsr_next(lf);
         net_msg_ok     = {lf, ~lf ^ 32'h0f0f_3c3c};
         if (lf[4:0] != 5'd5) begin
            li_exp[lf[4:0]] = lf[8];
            li_write(lf[4:0], lf[8], lf[9]);
         end
         lf = lfsr_next(lf);
         nc(2);
         `CHK("li_state", li_exp, li_state)
         `CHK("net_state", net_bit, net_state)
         `CHK("net_quality", ~net_msg_ok, net_quality)
      end
      end_of_test();
   end
endmodule
